/* verilog/dsp_engine.sv */
// serial link engine: makes the serial clock and shifts frames
// assumes a divided clock; device output sampled through two flops
`timescale 1ns/10ps
module dsp_engine (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic sdo_in,
  dsp_cmd_if.engine cif,
  output logic cs_n_r,
  output logic sclk_r,
  output logic sdi_r,
  output logic dcx_r
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LOW = 5'h02,
    ST_HIGH = 5'h04,
    ST_GAP = 5'h08,
    ST_DONE = 5'h10
  } dsp_st_type;
  dsp_st_type st_r;
  logic [15:0] sh_r;
  logic [4:0] nbit_r;
  logic [1:0] div_r;
  logic [3:0] gap_r;
  logic rd_r;
  logic [7:0] rx_r;
  logic s1_r;
  logic s2_r;
  logic [4:0] wlen;
  logic [2:0] smp_r;
  logic rise_w;
  always_comb
  begin
    unique case (cif.cmd.mode)
      dsp_pkg::MODE_NINE: wlen = 5'h09;
      dsp_pkg::MODE_SIXTEEN: wlen = 5'h10;
      default: wlen = 5'h08;
    endcase
    // read byte follows, dummy before several
    if (cif.cmd.rd && (cif.cmd.mode != dsp_pkg::MODE_SIXTEEN))
      wlen = wlen + 5'h08 + {4'h0, cif.cmd.nrd != 3'h0};
  end
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end
    else if (ce_in)
    begin
      s1_r <= sdo_in;
      s2_r <= s1_r;
    end
  end
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      st_r <= ST_IDLE;
      cs_n_r <= 1'b1;
      sclk_r <= 1'b1;
      sdi_r <= 1'b0;
      dcx_r <= 1'b0;
      sh_r <= 16'h0000;
      nbit_r <= 5'h00;
      div_r <= 2'h0;
      gap_r <= 4'h0;
      rd_r <= 1'b0;
    end
    else if (ce_in)
    begin
      div_r <= (div_r == 2'(dsp_pkg::DIV_HALF - 1)) ? 2'h0 : div_r + 2'h1;
      unique case (st_r)
        ST_IDLE:
        begin
          sclk_r <= 1'b1;
          if (cif.go)
          begin
            rd_r <= cif.cmd.rd;
            nbit_r <= wlen;
            dcx_r <= cif.cmd.kind;
            unique case (cif.cmd.mode)
              dsp_pkg::MODE_NINE: sh_r <= {cif.cmd.kind, cif.cmd.txd, 7'h00};
              dsp_pkg::MODE_SIXTEEN: sh_r <= {cif.cmd.rd, cif.cmd.kind, cif.cmd.hl, 5'h00, cif.cmd.txd};
              default: sh_r <= {cif.cmd.txd, 8'h00};
            endcase
            cs_n_r <= 1'b0;
            div_r <= 2'h0;
            st_r <= ST_LOW;
          end
        end
        ST_LOW:
        if (div_r == 2'(dsp_pkg::DIV_HALF - 1))
        begin
          // falling edge presents bit, msb first
          sclk_r <= 1'b0;
          sdi_r <= sh_r[15];
          sh_r <= {sh_r[14:0], 1'b0};
          st_r <= ST_HIGH;
        end
        ST_HIGH:
        if (div_r == 2'(dsp_pkg::DIV_HALF - 1))
        begin
          // rising edge, device bit sampled later
          sclk_r <= 1'b1;
          nbit_r <= nbit_r - 5'h01;
          if (nbit_r == 5'h01)
            st_r <= ST_GAP;
          else
            st_r <= ST_LOW;
        end
        ST_GAP:
        begin
          cs_n_r <= ~cif.cmd.pause;
          if (gap_r == 4'(dsp_pkg::PAUSE_CYC))
          begin
            gap_r <= 4'h0;
            st_r <= ST_DONE;
          end
          else
            gap_r <= gap_r + 4'h1;
        end
        ST_DONE:
        begin
          cs_n_r <= 1'b1;
          st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end
  assign rise_w = (st_r == ST_HIGH) && (div_r == 2'(dsp_pkg::DIV_HALF - 1));
  // take bit seen at pin rise, past sync delay
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      smp_r <= 3'h0;
      rx_r <= 8'h00;
    end
    else if (ce_in)
    begin
      smp_r <= {smp_r[1:0], rise_w};
      if (smp_r[2])
        rx_r <= {rx_r[6:0], s2_r};
    end
  end
  assign cif.busy = (st_r != ST_IDLE);
  assign cif.done = (st_r == ST_DONE);
  assign cif.rxd = rx_r;
endmodule : dsp_engine

/* verilog/dsp_pkg.sv */
// constants for the serial command port host controller
// assumes one system clock; serial clock made by division
//
// Function
// - three-wire nine-bit mode with select, clock, lines
// - four-wire mode adds command/data select line
// - host presents bit low, device latches rising
// - write framed by select fall and rise
// - device drives after fall, host samples rising
// - read framed by select, multiple bytes allowed
// - multi-byte read inserts one discarded dummy clock (engine adds none in sixteen-bit mode)
// - sixteen-bit framing sends exactly two bytes
// - first byte top bits: rw, kind, high/low
// - read/write flag one reads, zero writes
// - kind flag one data, zero command
// - high/low flag one means most significant byte
package dsp_pkg;
  // register offsets (byte addresses)
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] TXD_OFS = 4'h4;
  localparam logic [3:0] STAT_OFS = 4'h8;
  localparam logic [3:0] RXD_OFS = 4'hC;
  // control fields
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_RD_BIT = 1;
  localparam int CTRL_KIND_BIT = 2;
  localparam int CTRL_HL_BIT = 3;
  localparam int CTRL_MODE_LSB = 4;
  localparam int CTRL_NRD_LSB = 8;
  localparam int CTRL_PAUSE_BIT = 12;
  localparam logic [1:0] MODE_NINE = 2'h0;
  localparam logic [1:0] MODE_FOUR = 2'h1;
  localparam logic [1:0] MODE_SIXTEEN = 2'h2;
  localparam logic [1:0] SEL_SERIAL = 2'h1;
  localparam logic [31:0] CTRL_RST = 32'h0;
  localparam int DIV_HALF = 2;
  localparam int PAUSE_CYC = 4;
  typedef struct packed {
    logic rd;
    logic kind;
    logic hl;
    logic [1:0] mode;
    logic [2:0] nrd;
    logic pause;
    logic [7:0] txd;
  } dsp_cmd_type;
endpackage : dsp_pkg

/* verilog/dsp_cmd_if.sv */
// command/answer carrier between register front and link engine
// assumes both ends on clock_in
`timescale 1ns/10ps
interface dsp_cmd_if;
  logic go;
  dsp_pkg::dsp_cmd_type cmd;
  logic busy;
  logic done;
  logic [7:0] rxd;
  modport front (output go, output cmd, input busy, input done, input rxd);
  modport engine (input go, input cmd, output busy, output done, output rxd);
endinterface : dsp_cmd_if

/* verilog/dsp_host.sv */
// host controller for the serial command port of a display driver
// assumes avalon-mm master on clock_in; serial clock generated here
`timescale 1ns/10ps
module dsp_host (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic [3:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic avs_readdatavalid_out,
  input wire logic serial_out_line_in,
  output logic chip_select_n_out,
  output logic sclk_out,
  output logic serial_in_line_out,
  output logic cmd_data_select_line_out,
  output logic [1:0] interface_select_pins_out
);
  dsp_cmd_if cif ();
  logic [31:0] ctrl_r;
  logic [7:0] txd_r;
  logic [7:0] rxd_r;
  logic go_r;
  logic [2:0] left_r;
  logic dummy_r;
  logic cs_w;
  logic sclk_w;
  logic sdi_w;
  logic dcx_w;
  logic acc_w;
  dsp_engine u_eng (
    .clock_in(clock_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .sdo_in(serial_out_line_in),
    .cif(cif),
    .cs_n_r(cs_w),
    .sclk_r(sclk_w),
    .sdi_r(sdi_w),
    .dcx_r(dcx_w)
  );
  assign acc_w = ce_in & (avs_read_in | avs_write_in) & ~avs_waitrequest_out;
  // bus handshake: one wait cycle then accept
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
      avs_waitrequest_out <= 1'b1;
    else if (ce_in)
      avs_waitrequest_out <= ~(avs_waitrequest_out & (avs_read_in | avs_write_in));
  end
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      ctrl_r <= dsp_pkg::CTRL_RST;
      txd_r <= 8'h00;
      go_r <= 1'b0;
      left_r <= 3'h0;
      dummy_r <= 1'b0;
      rxd_r <= 8'h00;
    end
    else if (ce_in)
    begin
      go_r <= 1'b0;
      if (acc_w && avs_write_in && !cif.busy)
      begin
        if (avs_address_in == dsp_pkg::CTRL_OFS)
        begin
          ctrl_r <= avs_writedata_in;
          if (avs_writedata_in[dsp_pkg::CTRL_GO_BIT])
          begin
            go_r <= 1'b1;
            left_r <= avs_writedata_in[dsp_pkg::CTRL_NRD_LSB +: 3];
            // status dummy bit set only for reads of three or more bytes
            dummy_r <= avs_writedata_in[dsp_pkg::CTRL_RD_BIT] &&
                       (avs_writedata_in[dsp_pkg::CTRL_NRD_LSB +: 3] > 3'h1);
          end
        end
        else if (avs_address_in == dsp_pkg::TXD_OFS)
          txd_r <= avs_writedata_in[7:0];
      end
      if (cif.done)
      begin
        // each further read byte reissues the whole command frame
        rxd_r <= cif.rxd;
        if (left_r != 3'h0)
        begin
          left_r <= left_r - 3'h1;
          go_r <= 1'b1;
        end
      end
    end
  end
  assign cif.go = go_r;
  assign cif.cmd.rd = ctrl_r[dsp_pkg::CTRL_RD_BIT];
  assign cif.cmd.kind = ctrl_r[dsp_pkg::CTRL_KIND_BIT];
  assign cif.cmd.hl = ctrl_r[dsp_pkg::CTRL_HL_BIT];
  assign cif.cmd.mode = ctrl_r[dsp_pkg::CTRL_MODE_LSB +: 2];
  assign cif.cmd.nrd = ctrl_r[dsp_pkg::CTRL_NRD_LSB +: 3];
  assign cif.cmd.pause = ctrl_r[dsp_pkg::CTRL_PAUSE_BIT];
  assign cif.cmd.txd = txd_r;
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      avs_readdata_out <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      // read data loaded in the wait cycle, stands at accept
      if (avs_read_in && avs_waitrequest_out)
      begin
        unique case (avs_address_in)
          dsp_pkg::CTRL_OFS: avs_readdata_out <= ctrl_r;
          dsp_pkg::TXD_OFS: avs_readdata_out <= {24'h000000, txd_r};
          dsp_pkg::STAT_OFS: avs_readdata_out <= {28'h0000000, dummy_r, left_r == 3'h0, go_r, cif.busy};
          dsp_pkg::RXD_OFS: avs_readdata_out <= {24'h000000, rxd_r};
          default: avs_readdata_out <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign avs_readdatavalid_out = 1'b0;
  always_ff @(posedge clock_in)
  begin
    if (srst_in)
    begin
      chip_select_n_out <= 1'b1;
      sclk_out <= 1'b1;
      serial_in_line_out <= 1'b0;
      cmd_data_select_line_out <= 1'b0;
      interface_select_pins_out <= dsp_pkg::SEL_SERIAL;
    end
    else if (ce_in)
    begin
      chip_select_n_out <= cs_w;
      sclk_out <= sclk_w;
      serial_in_line_out <= sdi_w;
      cmd_data_select_line_out <= dcx_w;
      interface_select_pins_out <= dsp_pkg::SEL_SERIAL;
    end
  end
endmodule : dsp_host

/* tb/dsp_host_monitor.sv */
// port assertions for the host controller
// assumes bound to dsp_host, one clock domain
`timescale 1ns/10ps
module dsp_host_monitor (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic avs_readdatavalid_out,
  input wire logic chip_select_n_out,
  input wire logic sclk_out,
  input wire logic serial_in_line_out,
  input wire logic [1:0] interface_select_pins_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (srst_in);
  sequence s_low_half;
    !sclk_out ##1 !sclk_out;
  endsequence
  a_select_serial:
    assert property (interface_select_pins_out == 2'h1) else $error("select pins wrong");
  a_sclk_idle:
    assert property (chip_select_n_out |-> sclk_out) else $error("clock not idle high");
  a_sclk_framed:
    assert property (!$stable(sclk_out) |-> !chip_select_n_out) else $error("clock moved unselected");
  a_sdi_setup:
    assert property ($rose(sclk_out) |-> $stable(serial_in_line_out)) else $error("data moved at rise");
  a_frame_start:
    assert property ($fell(chip_select_n_out) |-> sclk_out) else $error("frame began low");
  a_low_half:
    assert property ($fell(sclk_out) |-> s_low_half) else $error("low phase short");
  a_wait_drop:
    assert property ($rose(avs_read_in || avs_write_in) |=> !avs_waitrequest_out) else $error("no accept");
  a_wait_one:
    assert property (!avs_waitrequest_out |=> avs_waitrequest_out) else $error("accept too long");
  a_rdv_low:
    assert property (!avs_readdatavalid_out) else $error("valid raised");
endmodule : dsp_host_monitor
bind dsp_host dsp_host_monitor u_mon (.clock_in(clock_in), .srst_in(srst_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
  .avs_readdatavalid_out(avs_readdatavalid_out), .chip_select_n_out(chip_select_n_out), .sclk_out(sclk_out),
  .serial_in_line_out(serial_in_line_out), .interface_select_pins_out(interface_select_pins_out));

/* tb/dsp_dev_model.sv */
// display driver serial port model
// assumes host clock idle high, one command per frame
`timescale 1ns/10ps
module dsp_dev_model (
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic sdi_in,
  input wire logic dcx_in,
  input wire logic [1:0] mode_in,
  input wire logic [7:0] resp_in,
  output logic sdo_out = 1'b0,
  output logic [15:0] rx_out = 16'h0,
  output logic dcx_out = 1'b0,
  output int nbits_out = 0
);
  int hdr;
  assign hdr = (mode_in == dsp_pkg::MODE_NINE) ? 9 : 8;
  always @(negedge cs_n_in) nbits_out <= 0;
  always @(posedge sclk_in)
    if (!cs_n_in)
    begin
      rx_out <= (nbits_out == 0) ? {15'h0000, sdi_in} : {rx_out[14:0], sdi_in};
      dcx_out <= dcx_in;
      nbits_out <= nbits_out + 1;
    end
  always @(negedge sclk_in or posedge cs_n_in)
    if (!cs_n_in && nbits_out >= hdr && nbits_out < hdr + 8)
      sdo_out <= resp_in[7 - (nbits_out - hdr)];
    else
      sdo_out <= ~sdo_out;
endmodule : dsp_dev_model

/* tb/dbi_serial_command_port_test.sv */
// self-checking bench for the host controller
// assumes device model on the serial pins
`timescale 1ns/10ps
module dbi_serial_command_port_test;
  logic clock_in = 0;
  logic srst_in = 1;
  logic rd_r = 0;
  logic wr_r = 0;
  logic [3:0] addr_r = 4'h0;
  logic [31:0] wd_r = 32'h0;
  logic [31:0] rdata, q;
  logic wt, rdv, cs_n, sclk, serial_in_line, cmd_data_select_line, serial_out_line, dcx_seen;
  logic [1:0] sel;
  logic [1:0] mode_r = 2'h0;
  logic [7:0] resp_r = 8'h0;
  logic [15:0] rx;
  logic [31:0] seed = 32'hC571;
  int nbits;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  dsp_host u_dut (.clock_in(clock_in), .srst_in(srst_in), .ce_in(1'b1), .avs_address_in(addr_r),
    .avs_read_in(rd_r), .avs_write_in(wr_r), .avs_writedata_in(wd_r), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wt), .avs_readdatavalid_out(rdv), .serial_out_line_in(serial_out_line),
    .chip_select_n_out(cs_n), .sclk_out(sclk), .serial_in_line_out(serial_in_line), .cmd_data_select_line_out(cmd_data_select_line),
    .interface_select_pins_out(sel));
  dsp_dev_model u_dev (.cs_n_in(cs_n), .sclk_in(sclk), .sdi_in(serial_in_line), .dcx_in(cmd_data_select_line), .mode_in(mode_r),
    .resp_in(resp_r), .sdo_out(serial_out_line), .rx_out(rx), .dcx_out(dcx_seen), .nbits_out(nbits));
  initial forever #4 clock_in = ~clock_in;
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [15:0] frame(input logic [1:0] m, input logic k, input logic h, input logic [7:0] t);
    if (m == dsp_pkg::MODE_NINE)
      return {7'h0, k, t};
    return (m == dsp_pkg::MODE_FOUR) ? {8'h0, t} : {1'b0, k, h, 5'h0, t};
  endfunction : frame
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    rd_r <= !w;
    wr_r <= w;
    addr_r <= a;
    wd_r <= d;
    do @(posedge clock_in); while (wt !== 1'b0);
    q = rdata;
    rd_r <= 1'b0;
    wr_r <= 1'b0;
    @(posedge clock_in);
  endtask : bus
  task automatic xfer(input logic [1:0] m, input logic r, input logic k, input logic h, input logic [7:0] t);
    logic [31:0] c;
    c = 32'h1;
    c[dsp_pkg::CTRL_RD_BIT] = r;
    c[dsp_pkg::CTRL_KIND_BIT] = k;
    c[dsp_pkg::CTRL_HL_BIT] = h;
    c[dsp_pkg::CTRL_MODE_LSB +: 2] = m;
    mode_r <= m;
    bus(1'b1, dsp_pkg::TXD_OFS, {24'h0, t});
    bus(1'b1, dsp_pkg::CTRL_OFS, c);
    bus(1'b1, dsp_pkg::TXD_OFS, {24'h0, ~t});
    do bus(1'b0, dsp_pkg::STAT_OFS, 32'h0); while (q[0] !== 1'b0);
  endtask : xfer
  always @(posedge clock_in)
    if (++cyc == 60000)
    begin
      errors++;
      complete_run;
    end
  initial
  begin
    repeat (10) @(posedge clock_in);
    srst_in <= 1'b0;
    @(posedge clock_in);
    bus(1'b0, dsp_pkg::CTRL_OFS, 32'h0);
    check(q, dsp_pkg::CTRL_RST);
    bus(1'b0, 4'h2, 32'h0);
    check(q, 32'h0);
    $display("reset test done");
    for (int i = 0; i < 12; i++)
    begin
      seed = lfsr(seed);
      xfer(2'(i % 3), 1'b0, seed[8], seed[9], seed[7:0]);
      check({16'h0, rx}, {16'h0, frame(2'(i % 3), seed[8], seed[9], seed[7:0])});
      check(nbits, (i % 3 == 0) ? 9 : (i % 3 == 1) ? 8 : 16);
      if (i % 3 == 1)
        check({31'h0, dcx_seen}, {31'h0, seed[8]});
    end
    $display("write test done");
    for (int i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      resp_r <= seed[15:8];
      xfer(2'(i % 3), 1'b1, 1'b0, 1'b0, seed[7:0]);
      check(nbits, (i % 3 == 0) ? 17 : 16);
      if (i % 3 == 2)
        check({31'h0, rx[15]}, 32'h1);
      bus(1'b0, dsp_pkg::RXD_OFS, 32'h0);
      check({24'h0, q[7:0]}, {24'h0, seed[15:8]});
    end
    $display("read test done");
    complete_run;
  end
endmodule : dbi_serial_command_port_test
